// file: rtl/adc_device.sv
// Converter end: serial register port, output coding and channel sequencer
// Behaviour
// - Unipolar result is straight binary
// - Bipolar result is offset binary
// - Polarity bit picks the coding
// - Burnout pair follows enable bit and channel
// - Missing reference clamps result to ones
// - Channel enables, pseudo, temp, short honoured
// - Sequencer visits each enabled channel once
// - Status low nibble names result channel
// - Append bit adds status to data
// - Host sets append with several channels
// - Channel change resets filter, waits settling
// - Data readable while next channel converts
// - Settling is four data rate periods
// - Every transaction starts with command byte
// - Data moves on din/dout by sclk
// - Ready low on new word, high otherwise
// - Repeat reads allowed except continuous read
// - Chip select enables; tied low works
// - Host idles sclk high
// - Chip select fall presents first bit
// - Forty ones reset port and registers
// - Host waits 500 us after reset
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.svh"
module adc_device #(
    parameter int ODR_CYCLES = `ODR_PERIOD_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    adc_if.device link,
    input wire logic [23:0] sample_code,
    input wire logic missing_ref,
    output logic [3:0] channel_select,
    output logic filter_reset,
    output logic burnout_on,
    output logic [3:0] burnout_pair,
    output logic pseudo_diff
);
    // Cycles of settling on one channel
    localparam int SETTLE = `SETTLE_PERIODS * ODR_CYCLES;

    // Link synchronisers
    logic cs_s1_q, cs_s2_q;      // Chip select chain
    logic din_s1_q, din_s2_q;    // Data in chain
    logic sck_s1_q, sck_s2_q;    // Serial clock chain
    logic sck_s3_q;              // Previous clock level for edge find
    logic sck_rise, sck_fall;    // Clock edges in our domain

    // Serial engine state
    adc_pkg::ser_state_type st_q, st_d;
    logic [5:0] bits_q, bits_d;    // Bit count within a word
    logic [31:0] sh_q, sh_d;       // Outgoing shift word
    logic [23:0] in_q, in_d;       // Incoming shift word
    logic [2:0] addr_q, addr_d;    // Target register
    logic [5:0] len_q, len_d;      // Bits in current word
    logic [23:0] mode_q, mode_d;   // Mode register
    logic [23:0] cfg_q, cfg_d;     // Configuration register
    logic cread_q, cread_d;        // Continuous read active
    logic [5:0] ones_q, ones_d;    // Consecutive ones on din
    logic srst_q, srst_d;          // Soft reset pulse
    logic dout_q, dout_d;          // Registered serial output
    logic read_done;               // Data register read finished

    // Sequencer state
    logic [3:0] chan_q, chan_d;    // Channel under conversion
    logic [19:0] cnt_q, cnt_d;     // Settling counter
    logic [23:0] data_q, data_d;   // Data register
    logic [3:0] sch_q, sch_d;      // Channel id of data register
    logic rdy_q, rdy_d;            // New word waiting
    logic filt_q, filt_d;          // Filter reset pulse
    logic upd;                     // Data register loaded now
    logic [7:0] en;                // Channel enables
    logic [3:0] eff;               // Id of what is converted
    logic [23:0] coded;            // Coded result
    logic [7:0] status;            // Status register view

    // Nearest enabled channel after cur, cur itself last
    function automatic logic [3:0] next_chan(input logic [7:0] e,
        input logic [3:0] cur);
        logic [3:0] n;
        logic [2:0] idx;
        n = cur;
        for (int i = 8; i >= 1; i--)
        begin
            idx = cur[2:0] + 3'(i);
            if (e[idx])
                n = {1'b0, idx};
        end
        return n;
    endfunction

    // Register width by address
    function automatic logic [5:0] reg_len(input logic [2:0] a,
        input logic app);
        if (a == `REG_STATUS)
            return 6'd8;
        else if (a == `REG_DATA && app)
            return 6'd32;
        else
            return 6'd24;
    endfunction

    // Two flops on every link input before use
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            {cs_s1_q, cs_s2_q} <= 2'b11;
            {din_s1_q, din_s2_q} <= 2'b00;
            {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'b111;
        end
        else if (ce)
        begin
            {cs_s1_q, cs_s2_q} <= {link.cs_n, cs_s1_q};
            {din_s1_q, din_s2_q} <= {link.din, din_s1_q};
            {sck_s1_q, sck_s2_q, sck_s3_q} <= {link.sclk, sck_s1_q, sck_s2_q};
        end
    end
    // Edges only count while selected
    assign sck_rise = sck_s2_q && !sck_s3_q && !cs_s2_q;
    assign sck_fall = !sck_s2_q && sck_s3_q && !cs_s2_q;

    // Status and coding views
    assign en = cfg_q[`CFG_CHAN_LSB +: 8];
    assign status = {~rdy_q, 1'b0, missing_ref, 1'b0, sch_q};
    always_comb
    begin
        if (cfg_q[`CFG_SHORT])
            eff = `CHAN_SHORT;
        else if (cfg_q[`CFG_TEMP])
            eff = `CHAN_TEMP;
        else
            eff = chan_q;
        if (missing_ref)
            coded = 24'hffffff;
        else if (cfg_q[`CFG_UNIPOLAR])
            coded = sample_code;
        else
            coded = sample_code ^ 24'h800000;
    end

    // Sequencer next state
    always_comb
    begin
        chan_d = chan_q;
        cnt_d = cnt_q + 20'd1;
        data_d = data_q;
        sch_d = sch_q;
        rdy_d = rdy_q;
        filt_d = 1'b0;
        upd = 1'b0;
        if (read_done)
            rdy_d = 1'b0;
        if (!(|en) && !cfg_q[`CFG_TEMP] && !cfg_q[`CFG_SHORT])
            cnt_d = 20'd0;
        else if (cnt_q == 20'(SETTLE - 2))
            rdy_d = 1'b0;
        else if (cnt_q >= 20'(SETTLE - 1))
        begin
            upd = 1'b1;
            data_d = coded;
            sch_d = eff;
            rdy_d = 1'b1;
            cnt_d = 20'd0;
            chan_d = next_chan(en, chan_q);
            filt_d = 1'b1;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk)
    begin
        if (!rst_n || (ce && srst_q))
        begin
            chan_q <= 4'h0;
            cnt_q <= 20'd0;
            data_q <= 24'h000000;
            sch_q <= 4'h0;
            rdy_q <= 1'b0;
            filt_q <= 1'b1;
        end
        else if (ce)
        begin
            chan_q <= chan_d;
            cnt_q <= cnt_d;
            data_q <= data_d;
            sch_q <= sch_d;
            rdy_q <= rdy_d;
            filt_q <= filt_d;
        end
    end

    // Serial engine next state
    always_comb
    begin
        logic [7:0] cmd;
        logic [23:0] word;
        logic [31:0] rv;
        cmd = {in_q[6:0], din_s2_q};
        word = {in_q[22:0], din_s2_q};
        rv = 32'h0;
        st_d = st_q;
        bits_d = bits_q;
        sh_d = sh_q;
        in_d = in_q;
        addr_d = addr_q;
        len_d = len_q;
        mode_d = mode_q;
        cfg_d = cfg_q;
        cread_d = cread_q;
        ones_d = ones_q;
        srst_d = 1'b0;
        read_done = 1'b0;
        if (cs_s2_q)
        begin
            st_d = adc_pkg::SER_COMM;
            bits_d = 6'd0;
        end
        else if (sck_rise)
        begin
            in_d = word;
            bits_d = bits_q + 6'd1;
            if (!din_s2_q)
                ones_d = 6'd0;
            else if (ones_q == `RESET_ONES - 6'd1)
            begin
                ones_d = 6'd0;
                srst_d = 1'b1;
            end
            else
                ones_d = ones_q + 6'd1;
            case (st_q)
                adc_pkg::SER_COMM:
                    if (bits_q == 6'd7)
                    begin
                        bits_d = 6'd0;
                        if (cread_q && cmd == `CREAD_EXIT)
                            cread_d = 1'b0;
                        else if (!cmd[`COMM_WEN_N])
                        begin
                            addr_d = cmd[5:3];
                            len_d = reg_len(cmd[5:3], mode_q[`MODE_APPEND]);
                            if (cmd[5:3] == `REG_STATUS)
                                rv = {status, 24'h0};
                            else if (cmd[5:3] == `REG_MODE)
                                rv = {mode_q, 8'h0};
                            else if (cmd[5:3] == `REG_CONFIG)
                                rv = {cfg_q, 8'h0};
                            else if (cmd[5:3] == `REG_DATA)
                                rv = {data_q, status};
                            else
                                rv = 32'h0;
                            if (!cmd[`COMM_READ])
                                st_d = adc_pkg::SER_WRITE;
                            else if (cmd[5:3] == `REG_DATA
                                && cmd[`COMM_CREAD])
                                cread_d = 1'b1;
                            else
                            begin
                                st_d = adc_pkg::SER_READ;
                                sh_d = rv;
                            end
                        end
                    end
                adc_pkg::SER_WRITE:
                    if (bits_q == len_q - 6'd1)
                    begin
                        st_d = adc_pkg::SER_COMM;
                        bits_d = 6'd0;
                        if (addr_q == `REG_MODE)
                            mode_d = word;
                        else if (addr_q == `REG_CONFIG)
                            cfg_d = word;
                    end
                default:
                    if (bits_q == len_q - 6'd1)
                    begin
                        st_d = adc_pkg::SER_COMM;
                        bits_d = 6'd0;
                        read_done = (addr_q == `REG_DATA);
                    end
            endcase
        end
        // First bit stands since the command; shift from the second on
        else if (sck_fall && st_q == adc_pkg::SER_READ && bits_q != 6'd0)
            sh_d = {sh_q[30:0], 1'b0};
        if (cread_q && upd)
        begin
            // New word replaces any unread one; read once only
            st_d = adc_pkg::SER_READ;
            // Status names the channel of the word now loaded
            sh_d = {data_d, 1'b0, 1'b0, missing_ref, 1'b0, sch_d};
            addr_d = `REG_DATA;
            len_d = reg_len(`REG_DATA, mode_q[`MODE_APPEND]);
            bits_d = 6'd0;
        end
        if (st_d == adc_pkg::SER_READ)
            dout_d = sh_d[31];
        else
            dout_d = ~rdy_d;
    end

    // Serial engine registers
    always_ff @(posedge clk)
    begin
        if (!rst_n || (ce && srst_q))
        begin
            st_q <= adc_pkg::SER_COMM;
            bits_q <= 6'd0;
            sh_q <= 32'h0;
            in_q <= 24'h0;
            addr_q <= 3'h0;
            len_q <= 6'd8;
            mode_q <= `MODE_RESET;
            cfg_q <= `CFG_RESET;
            cread_q <= 1'b0;
            ones_q <= 6'd0;
            srst_q <= 1'b0;
            dout_q <= 1'b1;
        end
        else if (ce)
        begin
            st_q <= st_d;
            bits_q <= bits_d;
            sh_q <= sh_d;
            in_q <= in_d;
            addr_q <= addr_d;
            len_q <= len_d;
            mode_q <= mode_d;
            cfg_q <= cfg_d;
            cread_q <= cread_d;
            ones_q <= ones_d;
            srst_q <= srst_d;
            dout_q <= dout_d;
        end
    end

    // Outputs
    assign link.dout = dout_q;
    assign link.dout_oe = ~cs_s2_q;
    assign channel_select = chan_q;
    assign filter_reset = filt_q;
    assign burnout_on = cfg_q[`CFG_BURN];
    assign burnout_pair = chan_q;
    assign pseudo_diff = cfg_q[`CFG_PSEUDO];
endmodule
`default_nettype wire

// file: shared/adc_defs.svh
// Offsets, field positions, reset values and timing counts of the converter link
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH
`define CLK_PERIOD_NS 10
`define ODR_PERIOD_NS 2000
`define SETTLE_PERIODS 4
`define RESET_ONES 6'd40
`define RESET_WAIT_US 500
`define REG_STATUS 3'h0
`define REG_MODE 3'h1
`define REG_CONFIG 3'h2
`define REG_DATA 3'h3
`define COMM_WEN_N 7
`define COMM_READ 6
`define COMM_CREAD 2
`define CREAD_EXIT 8'h58
`define MODE_APPEND 20
`define CFG_PSEUDO 18
`define CFG_SHORT 17
`define CFG_TEMP 16
`define CFG_CHAN_LSB 8
`define CFG_BURN 7
`define CFG_UNIPOLAR 3
`define MODE_RESET 24'h080060
`define CFG_RESET 24'h000100
`define CHAN_TEMP 4'h8
`define CHAN_SHORT 4'h9
`define H_CMD 32'h00000000
`define H_WDATA 32'h00000004
`define H_RDATA 32'h00000008
`define H_STATUS 32'h0000000c
`define H_CFG 32'h00000010
`define CMD_RESET_BIT 16
`define H_HALF_DEF 8
`endif

// file: shared/adc_pkg.sv
// Types shared by both ends of the converter link
`default_nettype none
package adc_pkg;
    // Serial engine state of the converter end
    typedef enum logic [1:0] {
        SER_COMM = 2'b00,
        SER_WRITE = 2'b01,
        SER_READ = 2'b10
    } ser_state_type;
    // Host frame state
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SETUP = 2'b01,
        H_LOW = 2'b10,
        H_HIGH = 2'b11
    } host_state_type;
endpackage
`default_nettype wire

// file: shared/adc_if.sv
// Serial link between host and converter
`timescale 1ns/1ps
`default_nettype none
interface adc_if;
    logic cs_n;      // Chip select, low active
    logic sclk;      // Serial clock from host
    logic din;       // Host to converter data
    logic dout;      // Converter data / ready
    logic dout_oe;   // Converter drives dout
    logic dout_line; // Resolved line, pulled high when undriven
    assign dout_line = dout_oe ? dout : 1'b1;
    modport device (input cs_n, input sclk, input din,
        output dout, output dout_oe);
    modport host (output cs_n, output sclk, output din, input dout_line);
endinterface
`default_nettype wire

// file: rtl/adc_host.sv
// Host end: APB command registers driving the serial link
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.svh"
module adc_host #(
    parameter int HALF = `H_HALF_DEF,
    parameter int RESET_WAIT = `RESET_WAIT_US * 1000 / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    adc_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    adc_pkg::host_state_type st_q, st_d;
    logic [39:0] tx_q, tx_d;     // Outgoing bits, first bit on top
    logic [31:0] rx_q, rx_d;     // Incoming bits
    logic [31:0] wd_q, wd_d;     // Write data register
    logic [31:0] rd_q, rd_d;     // Read data register
    logic [5:0] n_q, n_d;        // Data bits after command byte
    logic [5:0] tot_q, tot_d;    // Bits in frame
    logic [5:0] bit_q, bit_d;    // Bits done
    logic [15:0] hc_q, hc_d;     // Half period counter
    logic [31:0] wait_q, wait_d; // Quiet time after reset
    logic hold_q, hold_d;        // Keep chip select low when idle
    logic cs_q, cs_d, sck_q, sck_d, din_q, din_d;
    logic do_s1_q, do_s2_q;      // Data out synchroniser
    logic acc;                   // APB access edge
    logic [31:0] rdata_q, rdata_d; // Read word, captured in setup cycle
    logic [32:0] mask;           // Keeps the received bits

    // Two flops on the converter output
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            {do_s1_q, do_s2_q} <= 2'b11;
        else if (ce)
            {do_s1_q, do_s2_q} <= {link.dout_line, do_s1_q};
    end

    assign acc = psel && penable;
    assign mask = (33'h1 << n_q) - 33'h1;

    // Frame and register next state
    always_comb
    begin
        st_d = st_q;
        tx_d = tx_q;
        rx_d = rx_q;
        wd_d = wd_q;
        rd_d = rd_q;
        n_d = n_q;
        tot_d = tot_q;
        bit_d = bit_q;
        hc_d = hc_q + 16'd1;
        wait_d = (wait_q != 32'h0) ? wait_q - 32'h1 : 32'h0;
        hold_d = hold_q;
        cs_d = cs_q;
        sck_d = sck_q;
        din_d = din_q;
        if (acc && pwrite && paddr == `H_WDATA)
            wd_d = pwdata;
        else if (acc && pwrite && paddr == `H_CFG)
            hold_d = pwdata[0];
        case (st_q)
            adc_pkg::H_IDLE:
            begin
                cs_d = ~hold_q;
                sck_d = 1'b1;
                if (acc && pwrite && paddr == `H_CMD && wait_q == 32'h0)
                begin
                    st_d = adc_pkg::H_SETUP;
                    cs_d = 1'b0;
                    hc_d = 16'd0;
                    bit_d = 6'd0;
                    if (pwdata[`CMD_RESET_BIT])
                    begin
                        tx_d = {40{1'b1}};
                        tot_d = 6'd40;
                        n_d = 6'd0;
                    end
                    else
                    begin
                        n_d = (pwdata[13:8] > 6'd32) ? 6'd32 : pwdata[13:8];
                        tot_d = 6'd8 + n_d;
                        tx_d = {pwdata[7:0], wd_q << (6'd32 - n_d)};
                    end
                end
            end
            adc_pkg::H_SETUP:
                if (hc_q == 16'(HALF - 1))
                begin
                    st_d = adc_pkg::H_LOW;
                    hc_d = 16'd0;
                    sck_d = 1'b0;
                    din_d = tx_q[39];
                end
            adc_pkg::H_LOW:
                if (hc_q == 16'(HALF - 1))
                begin
                    st_d = adc_pkg::H_HIGH;
                    hc_d = 16'd0;
                    sck_d = 1'b1;
                    rx_d = {rx_q[30:0], do_s2_q};
                    tx_d = {tx_q[38:0], 1'b0};
                    bit_d = bit_q + 6'd1;
                end
            default:
                if (hc_q == 16'(HALF - 1))
                begin
                    hc_d = 16'd0;
                    if (bit_q == tot_q)
                    begin
                        st_d = adc_pkg::H_IDLE;
                        cs_d = ~hold_q;
                        din_d = 1'b0;
                        rd_d = rx_q & mask[31:0];
                        if (tot_q == 6'd40)
                            wait_d = 32'(RESET_WAIT);
                    end
                    else
                    begin
                        st_d = adc_pkg::H_LOW;
                        sck_d = 1'b0;
                        din_d = tx_q[39];
                    end
                end
        endcase
    end

    // Frame and register state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= adc_pkg::H_IDLE;
            tx_q <= 40'h0;
            rx_q <= 32'h0;
            wd_q <= 32'h0;
            rd_q <= 32'h0;
            n_q <= 6'd0;
            tot_q <= 6'd0;
            bit_q <= 6'd0;
            hc_q <= 16'd0;
            wait_q <= 32'h0;
            hold_q <= 1'b0;
            cs_q <= 1'b1;
            sck_q <= 1'b1;
            din_q <= 1'b0;
        end
        else if (ce)
        begin
            st_q <= st_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            n_q <= n_d;
            tot_q <= tot_d;
            bit_q <= bit_d;
            hc_q <= hc_d;
            wait_q <= wait_d;
            hold_q <= hold_d;
            cs_q <= cs_d;
            sck_q <= sck_d;
            din_q <= din_d;
        end
    end

    // Read mux, zero for unmapped addresses
    always_comb
    begin
        if (paddr == `H_WDATA)
            rdata_d = wd_q;
        else if (paddr == `H_RDATA)
            rdata_d = rd_q;
        else if (paddr == `H_STATUS)
            rdata_d = {30'h0, ~do_s2_q & ~cs_q,
                (st_q != adc_pkg::H_IDLE) || (wait_q != 32'h0)};
        else if (paddr == `H_CFG)
            rdata_d = {31'h0, hold_q};
        else
            rdata_d = 32'h0;
    end
    // Word taken in the setup cycle stands through the access phase
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_q <= 32'h0;
        else if (ce && psel && !penable)
            rdata_q <= rdata_d;
    end
    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign link.cs_n = cs_q;
    assign link.sclk = sck_q;
    assign link.din = din_q;
endmodule
`default_nettype wire

// file: test/adc_link_assertions.sv
// Timing checks on the serial link between host and converter
`timescale 1ns/1ps
`default_nettype none
module adc_link_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic sclk_q; // Clock level one cycle ago
    logic [5:0] rise_q; // Clock rises in this frame
    logic [5:0] rise_d;
    // Count rises while selected
    always_comb
    begin
        rise_d = rise_q;
        if (cs_n)
            rise_d = 6'h00;
        else if (sclk && !sclk_q)
            rise_d = rise_q + 6'h01;
    end
    // Register count and level
    always_ff @(posedge clk)
    begin
        sclk_q <= rst_n ? sclk : 1'b1;
        rise_q <= rst_n ? rise_d : 6'h00;
    end
    idle_clock_high_a: assert property (cs_n |-> sclk)
        else $error("serial clock low while deselected");
    sel_drives_out_a: assert property ($fell(cs_n) |-> ##[1:4] dout_oe)
        else $error("data out not driven after select");
    desel_release_a: assert property ($rose(cs_n) |-> ##[1:4] !dout_oe)
        else $error("data out still driven after deselect");
    cs_lead_a: assert property ($fell(cs_n) |-> sclk[*6])
        else $error("clock moved too soon after select");
    low_phase_a: assert property ($fell(sclk) |-> !sclk[*6] ##[1:6] sclk)
        else $error("clock low phase wrong");
    high_phase_a: assert property ($rose(sclk) |-> sclk[*6])
        else $error("clock high phase too short");
    din_hold_a: assert property ($rose(sclk) |-> ##1 $stable(din)[*6])
        else $error("data in moved while clock high");
    frame_bits_a: assert property ($rose(cs_n) |-> rise_q >= 6'd8 && rise_q <= 6'd40)
        else $error("frame bit count out of range");
endmodule
`default_nettype wire

// file: test/adc_serial_port_channel_sequencer_bench.sv
// Bench: host and converter joined over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.svh"
module adc_serial_port_channel_sequencer_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [23:0] sample_code = 24'h123456; // Analog stand-in
    logic missing_ref = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic [3:0] channel_select;
    logic [3:0] burnout_pair;
    logic burnout_on;
    logic filter_reset;
    logic pseudo_diff;
    logic [31:0] r; // Last answer
    int n_errors = 0;
    int n_tests = 0;
    adc_if link_if();
    adc_device #(.ODR_CYCLES(10)) adc_device_inst (.clk(clk), .rst_n(rst_n),
        .ce(ce), .link(link_if), .sample_code(sample_code),
        .missing_ref(missing_ref), .channel_select(channel_select),
        .filter_reset(filter_reset), .burnout_on(burnout_on),
        .burnout_pair(burnout_pair), .pseudo_diff(pseudo_diff));
    adc_host #(.RESET_WAIT(20)) adc_host_inst (.clk(clk), .rst_n(rst_n),
        .ce(ce), .link(link_if), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr());
    adc_link_assertions adc_link_assertions_inst (.clk(clk), .rst_n(rst_n),
        .cs_n(link_if.cs_n), .sclk(link_if.sclk), .din(link_if.din),
        .dout_oe(link_if.dout_oe));
    // Free running clock
    always #5 clk = ~clk;
    // Print counts and verdict, then stop
    task automatic tally_and_finish();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, waiting for pready
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50)
            chk(32'h0, 32'h1);
        if (k == 50)
            tally_and_finish();
    endtask
    // Poll status until the given bit reads v
    task automatic poll(input int b, input logic v);
        int k;
        logic [31:0] q;
        k = 0;
        do
        begin
            apb(1'b0, `H_STATUS, 32'h0, q);
            k++;
        end
        while (q[b] !== v && k < 2000);
        if (k == 2000)
            chk(q, 32'(v) << b);
        if (k == 2000)
            tally_and_finish();
    endtask
    // Full frame: command word c, data d, received bits into q
    task automatic xfer(input logic [31:0] c, input logic [31:0] d,
        output logic [31:0] q);
        poll(0, 1'b0);
        apb(1'b1, `H_WDATA, d, q);
        apb(1'b1, `H_CMD, c, q);
        poll(0, 1'b0);
        apb(1'b0, `H_RDATA, 32'h0, q);
    endtask
    // Follow the sequencer across enabled channels 0, 2, 5
    task automatic seq();
        logic [3:0] p;
        logic [3:0] nx;
        int g;
        p = channel_select;
        for (int i = 0; i < 7; i++)
        begin
            g = 0;
            while (channel_select === p && g < 400)
            begin
                @(negedge clk);
                g++;
            end
            nx = (p == 4'h0) ? 4'h2 : (p == 4'h2) ? 4'h5 : 4'h0;
            chk(32'(channel_select), 32'(nx));
            chk(32'(burnout_pair), 32'(nx));
            chk(32'(filter_reset), 32'h1);
            if (i > 0)
                chk(32'(g), 32'(`SETTLE_PERIODS * 10));
            if (g == 400)
                tally_and_finish();
            p = nx;
        end
        @(negedge clk);
        chk(32'(filter_reset), 32'h0);
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        xfer(32'h1848, 32'h0, r);
        chk({8'h0, r[23:0]}, {8'h0, `MODE_RESET});
        xfer(32'h1810, 32'h002588, r);
        xfer(32'h1850, 32'h0, r);
        chk({8'h0, r[23:0]}, 32'h002588);
        chk(32'(burnout_on), 32'h1);
        chk(32'(pseudo_diff), 32'h0);
        seq();
        xfer(32'h1808, 32'h180060, r);
        xfer(32'h2058, 32'h0, r);
        chk({8'h0, r[31:8]}, 32'h123456);
        chk(32'(r[3:0] == 4'h0 || r[3:0] == 4'h2 || r[3:0] == 4'h5), 32'h1);
        sample_code <= 24'h800000;
        xfer(32'h1810, 32'h042580, r);
        chk(32'(pseudo_diff), 32'h1);
        repeat (130) @(posedge clk);
        xfer(32'h2058, 32'h0, r);
        chk({8'h0, r[31:8]}, 32'h0);
        missing_ref <= 1'b1;
        repeat (130) @(posedge clk);
        xfer(32'h2058, 32'h0, r);
        chk({8'h0, r[31:8]}, 32'hffffff);
        missing_ref <= 1'b0;
        sample_code <= 24'h123456;
        apb(1'b0, 32'h20, 32'h0, r);
        chk(r, 32'h0);
        xfer(32'h10000, 32'h0, r);
        xfer(32'h1850, 32'h0, r);
        chk({8'h0, r[23:0]}, {8'h0, `CFG_RESET});
        apb(1'b1, `H_CFG, 32'h1, r);
        poll(1, 1'b1);
        xfer(32'h1858, 32'h0, r);
        chk({8'h0, r[23:0]}, 32'h923456);
        tally_and_finish();
    end
endmodule
`default_nettype wire
